// *** src/frtc_pkg.sv ***
/*
 * Constants for the free-running timer with input capture: register
 * offsets, bit positions inside the byte-wide registers, reset values
 * and timing figures.
 * Assumes an 8-bit register port whose addresses are byte offsets.
 */
package frtc_pkg;

    // =====================================================================
    // Register offsets
    // =====================================================================
    localparam logic [7:0] timer_control_addr = 8'h12;       // Control bits
    localparam logic [7:0] timer_flags_addr = 8'h13;         // Event flags
    localparam logic [7:0] capture_high_addr = 8'h14;        // Capture MSB
    localparam logic [7:0] capture_low_addr = 8'h15;         // Capture LSB
    localparam logic [7:0] count_high_addr = 8'h18;          // Main count MSB
    localparam logic [7:0] count_low_addr = 8'h19;           // Main count LSB
    localparam logic [7:0] alt_count_high_addr = 8'h1a;      // Alternate MSB
    localparam logic [7:0] alt_count_low_addr = 8'h1b;       // Alternate LSB
    localparam logic [7:0] analog_control_addr = 8'h1d;      // Source select

    // =====================================================================
    // Field positions
    // =====================================================================
    localparam int capture_irq_enable_bit = 7;   // In timer_control
    localparam int overflow_irq_enable_bit = 5;  // In timer_control
    localparam int capture_edge_select_bit = 1;  // In timer_control
    localparam int capture_flag_bit = 7;         // In timer_flags
    localparam int overflow_flag_bit = 5;        // In timer_flags
    localparam int capture_source_select_bit = 4; // In analog_control

    // =====================================================================
    // Values and timing
    // =====================================================================
    localparam logic [15:0] count_preset = 16'hfffc;   // Count after reset
    localparam logic [15:0] count_last = 16'hffff;     // Value before wrap
    localparam logic [1:0] prescale_last = 2'h3;       // Divide by four
    localparam logic [7:0] read_idle = 8'h00;          // Data when no read
    localparam int startup_delay_cycles = 4064;        // Oscillator startup
    localparam int startup_width = 16;                 // Startup counter bits

endpackage : frtc_pkg

// *** src/frtc_timer.sv ***
/*
 * Sixteen-bit free-running timer with main and alternate read pairs,
 * overflow flag and interrupt, and input capture from a pin or from the
 * comparator 2 flag.
 * Assumes a single-cycle register port with read data one cycle later,
 * capture inputs that are asynchronous, and a one-cycle device reset.
 */
// Chosen here: the plain strobed port.
// What this block does
// - Counter advances every four bus clocks
// - Counter reads never disturb counting
// - Device reset presets counter to fffc
// - After power-on, wait startup delay first
// - Main count registers ignore writes
// - Main high read freezes low byte
// - Wrap from ffff sets overflow flag
// - Overflow flag with enable raises interrupt
// - Flag read, then low read clears overflow
// - Alternate pair never clears overflow flag
// - Alternate count registers ignore writes
// - Alternate high read freezes alternate low
// - Source select picks pin or comparator
// - Active edge copies counter into capture
// - Edge select bit chooses trigger polarity
// - One rising, zero falling; reset keeps it
// - Captured value is prior count plus one
// - Reset keeps capture registers
// - Capture high read blocks new captures
// - Flag read, then low read clears capture
// - Active edge sets capture flag; reset keeps
// - Capture low read never conflicts
// - Flag writes ignored; reset keeps flags
`timescale 1ns/1ps

module frtc_timer #(
    parameter int startup_cycles = frtc_pkg::startup_delay_cycles
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic dev_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic capture_pin,
    input wire logic comparator2_flag,
    output logic timer_irq
);

    // =====================================================================
    // State
    // =====================================================================
    typedef struct packed {
        logic [1:0] prescale;        // Divide-by-four stage
        logic [15:0] count;          // Free-running counter
        logic [15:0] startup;        // Startup delay counter
        logic started;               // Delay has elapsed
        logic capture_irq_enable;    // Control bit
        logic overflow_irq_enable;   // Control bit
        logic capture_edge_select;   // Control bit, kept over device reset
        logic capture_source_select; // Analog control bit
        logic overflow_flag;         // Sticky wrap flag
        logic capture_flag;          // Sticky capture flag
        logic overflow_armed;        // Flag seen set by a flags read
        logic capture_armed;         // Flag seen set by a flags read
        logic low_frozen;            // Main low byte held
        logic [7:0] low_held;        // Main held low byte
        logic alt_low_frozen;        // Alternate low byte held
        logic [7:0] alt_low_held;    // Alternate held low byte
        logic capture_blocked;       // Capture high read, low pending
        logic [15:0] capture;        // Captured count
        logic pin_meta;              // Pin synchroniser, first stage
        logic pin_sync;              // Pin synchroniser, second stage
        logic cmp_meta;              // Comparator synchroniser, first stage
        logic cmp_sync;              // Comparator synchroniser, second stage
        logic source_prev;           // Selected source, one cycle back
        logic [7:0] rd_data;         // Registered read data
        logic irq;                   // Registered interrupt request
    } frtc_state_type;

    frtc_state_type st;       // Current state
    frtc_state_type next_st;  // Next state
    logic tick;               // Counter advances this cycle
    logic edge_hit;           // Active edge on selected source
    logic cap_evt;            // Capture taken this cycle
    logic source_now;         // Selected synchronised source

    // Startup count in cycles, trimmed to the counter width
    localparam logic [15:0] startup_last = 16'(startup_cycles - 1);

    // Next count value, shared by the counter and the capture path
    function automatic logic [15:0] frtc_inc(input logic [15:0] v);
        frtc_inc = 16'(v + 16'h0001);
    endfunction

    // =====================================================================
    // Next-state logic
    // =====================================================================
    // All behaviour in one place so that set and clear can be ordered
    always_comb begin
        logic ovf_set;
        logic ovf_clr;
        logic cap_clr;
        next_st = st;
        ovf_set = 1'b0;
        ovf_clr = 1'b0;
        cap_clr = 1'b0;
        next_st.rd_data = frtc_pkg::read_idle;

        // Startup delay runs once after power-on only
        if (!st.started) begin
            if (st.startup == startup_last) begin
                next_st.started = 1'b1;
            end else begin
                next_st.startup = frtc_inc(st.startup);
            end
        end

        // Prescaler and counter; reads never touch either
        tick = st.started && (st.prescale == frtc_pkg::prescale_last);
        if (st.started) begin
            next_st.prescale = 2'(st.prescale + 2'h1);
        end
        if (tick) begin
            next_st.count = frtc_inc(st.count);
            if (st.count == frtc_pkg::count_last) begin
                ovf_set = 1'b1;
            end
        end

        // Synchronisers; first stages feed only second stages
        next_st.pin_meta = capture_pin;
        next_st.pin_sync = st.pin_meta;
        next_st.cmp_meta = comparator2_flag;
        next_st.cmp_sync = st.cmp_meta;

        // Source mux, then edge of chosen polarity
        source_now = st.capture_source_select ? st.cmp_sync : st.pin_sync;
        next_st.source_prev = source_now;
        if (st.capture_edge_select) begin
            edge_hit = source_now && !st.source_prev;
        end else begin
            edge_hit = !source_now && st.source_prev;
        end
        // Capture takes one more than the count seen at the edge,
        // which stands for the synchroniser delay
        cap_evt = edge_hit && !st.capture_blocked;
        if (cap_evt) begin
            next_st.capture = frtc_inc(st.count);
        end

        // Register reads
        if (reg_rd) begin
            case (reg_addr)
                frtc_pkg::timer_control_addr: begin
                    next_st.rd_data[frtc_pkg::capture_irq_enable_bit] = st.capture_irq_enable;
                    next_st.rd_data[frtc_pkg::overflow_irq_enable_bit] =
                        st.overflow_irq_enable;
                    next_st.rd_data[frtc_pkg::capture_edge_select_bit] =
                        st.capture_edge_select;
                end
                frtc_pkg::timer_flags_addr: begin
                    next_st.rd_data[frtc_pkg::capture_flag_bit] = st.capture_flag;
                    next_st.rd_data[frtc_pkg::overflow_flag_bit] = st.overflow_flag;
                    // Arm only the flags that this read saw set
                    next_st.overflow_armed = st.overflow_flag;
                    next_st.capture_armed = st.capture_flag;
                end
                frtc_pkg::count_high_addr: begin
                    next_st.rd_data = st.count[15:8];
                    // Repeated high reads keep the first held byte
                    if (!st.low_frozen) begin
                        next_st.low_frozen = 1'b1;
                        next_st.low_held = st.count[7:0];
                    end
                end
                frtc_pkg::count_low_addr: begin
                    next_st.rd_data = st.low_frozen ? st.low_held : st.count[7:0];
                    next_st.low_frozen = 1'b0;
                    if (st.overflow_armed) begin
                        ovf_clr = 1'b1;
                        next_st.overflow_armed = 1'b0;
                    end
                end
                frtc_pkg::alt_count_high_addr: begin
                    next_st.rd_data = st.count[15:8];
                    if (!st.alt_low_frozen) begin
                        next_st.alt_low_frozen = 1'b1;
                        next_st.alt_low_held = st.count[7:0];
                    end
                end
                frtc_pkg::alt_count_low_addr: begin
                    // No flag side effects on this pair
                    next_st.rd_data = st.alt_low_frozen ? st.alt_low_held : st.count[7:0];
                    next_st.alt_low_frozen = 1'b0;
                end
                frtc_pkg::capture_high_addr: begin
                    next_st.rd_data = st.capture[15:8];
                    next_st.capture_blocked = 1'b1;
                end
                frtc_pkg::capture_low_addr: begin
                    // Old value returned even if a capture lands now
                    next_st.rd_data = st.capture[7:0];
                    next_st.capture_blocked = 1'b0;
                    if (st.capture_armed) begin
                        cap_clr = 1'b1;
                        next_st.capture_armed = 1'b0;
                    end
                end
                frtc_pkg::analog_control_addr: begin
                    next_st.rd_data[frtc_pkg::capture_source_select_bit] =
                        st.capture_source_select;
                end
                default: begin
                    next_st.rd_data = frtc_pkg::read_idle; // Unmapped reads zero
                end
            endcase
        end

        // Register writes; count, capture and flag writes fall to default
        if (reg_wr) begin
            case (reg_addr)
                frtc_pkg::timer_control_addr: begin
                    next_st.capture_irq_enable = reg_wdata[frtc_pkg::capture_irq_enable_bit];
                    next_st.overflow_irq_enable = reg_wdata[frtc_pkg::overflow_irq_enable_bit];
                    next_st.capture_edge_select = reg_wdata[frtc_pkg::capture_edge_select_bit];
                end
                frtc_pkg::analog_control_addr: begin
                    next_st.capture_source_select =
                        reg_wdata[frtc_pkg::capture_source_select_bit];
                end
                default: begin
                    next_st.count = next_st.count;
                end
            endcase
        end

        // Flags: an event in the clearing cycle wins
        next_st.overflow_flag = (st.overflow_flag && !ovf_clr) || ovf_set;
        next_st.capture_flag = (st.capture_flag && !cap_clr) || edge_hit;

        // Device reset: flags, edge select and capture are kept
        if (dev_rst) begin
            next_st.count = frtc_pkg::count_preset;
            next_st.prescale = 2'h0;
            next_st.capture_irq_enable = 1'b0;
            next_st.overflow_irq_enable = 1'b0;
            next_st.capture_source_select = 1'b0;
            next_st.low_frozen = 1'b0;
            next_st.alt_low_frozen = 1'b0;
            next_st.capture_blocked = 1'b0;
        end

        // Interrupt request from the next flags and enables, registered with them
        next_st.irq = (next_st.overflow_flag && next_st.overflow_irq_enable) ||
            (next_st.capture_flag && next_st.capture_irq_enable);
    end

    // =====================================================================
    // State register
    // =====================================================================
    // Power-on gives every bit a value; the startup delay then runs
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0;
            st.count <= frtc_pkg::count_preset;
        end else begin
            st <= next_st;
        end
    end

    assign reg_rdata = st.rd_data;
    assign timer_irq = st.irq;

    // =====================================================================
    // Assertions
    // =====================================================================
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    a_count_step: assert property (
        tick && !dev_rst |=> st.count == frtc_inc($past(st.count)))
        else $error("Counter did not step on prescaler tick");

    // Three quiet cycles follow each step unless a device reset cuts in
    a_divide_four: assert property (
        tick && !dev_rst ##1 !dev_rst [*3] |=> st.count == $past(st.count, 3))
        else $error("Counter moved between prescaler ticks");

    a_preset_value: assert property (dev_rst |=> st.count == frtc_pkg::count_preset)
        else $error("Device reset did not preset the counter");

    a_startup_hold: assert property (!st.started |-> st.count == frtc_pkg::count_preset)
        else $error("Counter moved before startup delay ended");

    // Wrap sets the flag in the same step as the count
    a_overflow_set: assert property (
        tick && !dev_rst && st.count == frtc_pkg::count_last
        |=> st.overflow_flag && st.count == 16'h0000)
        else $error("Wrap did not set overflow flag");

    // Request is registered beside the flag, so both stand in one cycle
    a_irq_follow: assert property (
        st.overflow_flag && st.overflow_irq_enable |-> timer_irq)
        else $error("Overflow interrupt not raised");

    // A fall needs an armed low read in the cycle before
    a_overflow_clear: assert property (
        $fell(st.overflow_flag) |-> $past(reg_rd) &&
        $past(reg_addr) == frtc_pkg::count_low_addr && $past(st.overflow_armed))
        else $error("Overflow flag cleared without armed low read");

    a_alt_keeps_flag: assert property (
        reg_rd && reg_addr == frtc_pkg::alt_count_low_addr && st.overflow_flag
        |=> st.overflow_flag)
        else $error("Alternate read cleared overflow flag");

    // Only the matching low read or a device reset releases the held byte
    a_low_frozen: assert property (
        st.low_frozen && !dev_rst && !(reg_rd && reg_addr == frtc_pkg::count_low_addr)
        |=> st.low_frozen && $stable(st.low_held))
        else $error("Held main low byte changed");

    a_alt_frozen: assert property (
        st.alt_low_frozen && !dev_rst &&
        !(reg_rd && reg_addr == frtc_pkg::alt_count_low_addr)
        |=> st.alt_low_frozen && $stable(st.alt_low_held))
        else $error("Held alternate low byte changed");

    a_capture_value: assert property (
        cap_evt && !dev_rst |=> st.capture == frtc_inc($past(st.count)))
        else $error("Captured value not prior count plus one");

    a_capture_block: assert property (st.capture_blocked |=> $stable(st.capture))
        else $error("Capture taken while blocked");

    a_capture_flag: assert property (edge_hit |=> st.capture_flag)
        else $error("Active edge did not set capture flag");

    // =====================================================================
    // Reset keeps and capture flag clear
    // =====================================================================
    // Device reset leaves flags, edge select and capture alone
    a_flag_kept: assert property (
        dev_rst && !reg_rd && st.capture_flag |=> st.capture_flag)
        else $error("Device reset cleared capture flag");

    a_edge_kept: assert property (
        dev_rst && !reg_wr |=> $stable(st.capture_edge_select))
        else $error("Device reset changed edge select");

    a_capture_kept: assert property (
        dev_rst && !cap_evt |=> $stable(st.capture))
        else $error("Device reset changed capture value");

    // A fall of the capture flag needs an armed capture low read
    a_capture_clear: assert property (
        $fell(st.capture_flag) |-> $past(reg_rd) &&
        $past(reg_addr) == frtc_pkg::capture_low_addr && $past(st.capture_armed))
        else $error("Capture flag cleared without armed low read");

    // =====================================================================
    // Cover points
    // =====================================================================

    c_overflow_irq: cover property (st.overflow_flag && st.overflow_irq_enable ##2 timer_irq);
    c_capture_taken: cover property (cap_evt ##1 reg_rd && reg_addr == frtc_pkg::capture_low_addr);
    c_capture_blocked: cover property (st.capture_blocked && edge_hit);
    c_alt_pair: cover property (reg_rd && reg_addr == frtc_pkg::alt_count_high_addr ##[1:8]
        reg_rd && reg_addr == frtc_pkg::alt_count_low_addr);
    c_overflow_clear: cover property ($fell(st.overflow_flag));

endmodule // frtc_timer

// *** dv/frtc_capture_src.sv ***
/*
 * Model of the capture sources: the external capture pin and the
 * comparator 2 flag, both driven as plain logic levels.
 * Assumes the bench calls drive() just after a clock edge; lines change
 * by non-blocking assignment at a later rising edge, lag edges further on.
 */
`timescale 1ns/1ps

module frtc_capture_src (
    input wire logic sys_clk,
    output logic capture_pin,
    output logic comparator2_flag
);
    // =====================================================================
    // Idle levels
    // =====================================================================
    // Both sources start low so the first rising edge is a clean one
    initial begin
        capture_pin = 1'b0;
        comparator2_flag = 1'b0;
    end

    // =====================================================================
    // Edge generation
    // =====================================================================
    // Lag gives a slow answer; zero lag answers promptly
    task automatic drive(input logic line, input logic level, input int lag);
        repeat (lag) @(posedge sys_clk);
        @(posedge sys_clk);
        if (line) begin
            comparator2_flag <= level; // Comparator source
        end else begin
            capture_pin <= level; // Pin source
        end
    endtask
endmodule // frtc_capture_src

// *** dv/tb_top.sv ***
/*
 * Self-checking bench for the free-running timer: power-on preset,
 * counting rate, read pairs, overflow flag and capture unit.
 * Assumes frtc_capture_src drives the capture inputs.
 */
`timescale 1ns/1ps

module tb_top;
    // =====================================================================
    // Signals
    // =====================================================================
    logic sys_clk = 1'b0; // 100 MHz clock
    logic sys_rst = 1'b1; // Power-on reset
    logic dev_rst = 1'b0; // Device reset
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic capture_pin;
    logic comparator2_flag;
    logic timer_irq;
    int num_errors = 0;
    int samples_checked = 0;
    logic [15:0] v0, v1, cap, last_cap; // Scratch values
    logic [7:0] b; // Read data; rdchk checks it, other reads discard it
    // Capture cases: edge select, source, line, level, capture expected
    localparam logic [4:0] cases [6] = '{5'h13, 5'h10, 5'h02, 5'h01, 5'h1f, 5'h1a};

    always #5 sys_clk = ~sys_clk; // Half period

    // Short startup so the run stays brief
    frtc_timer #(.startup_cycles(8)) i_frtc_timer (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .dev_rst(dev_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .capture_pin(capture_pin),
        .comparator2_flag(comparator2_flag), .timer_irq(timer_irq));
    frtc_capture_src i_frtc_capture_src (.sys_clk(sys_clk), .capture_pin(capture_pin),
        .comparator2_flag(comparator2_flag));

    // =====================================================================
    // Bus and compare tasks
    // =====================================================================
    // Every task returns 1 ns after an edge, so the next request is taken
    // at the following edge with no gap
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata; // Data stands only in this cycle
    endtask
    task automatic rdchk(input string what, input logic [7:0] a, input logic [7:0] exp);
        rd(a, b);
        chk(what, {8'h00, exp}, {8'h00, b});
    endtask
    task automatic rd16(input logic [7:0] a, output logic [15:0] v);
        rd(a, v[15:8]);
        // Low read follows the high at once, so nothing splits the pair
        rd(a + 8'h01, v[7:0]);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // Bounded wait; running out shows up as a mismatch
    task automatic irq_check(input logic exp);
        int n;
        n = 0;
        while (timer_irq !== exp && n < 4) begin
            idle(1);
            n++;
        end
        chk("timer_irq", {15'h0000, exp}, {15'h0000, timer_irq});
    endtask
    task automatic dev_reset();
        dev_rst <= 1'b1;
        idle(1);
        dev_rst <= 1'b0;
    endtask
    // High reads forty cycles apart must differ by exactly ten counts,
    // with writes in between and a stray second high read before the low read
    task automatic count_check(input logic [7:0] ref_a, input logic [7:0] chk_a);
        logic [15:0] r;
        logic [15:0] c;
        rd16(ref_a, r);
        for (int i = 0; i < 4; i++) wr(frtc_pkg::count_high_addr + i[7:0], 8'h00);
        idle(34);
        rd(chk_a, c[15:8]);
        idle(19);
        rd(chk_a, b);
        rd(chk_a + 8'h01, c[7:0]);
        chk("count after forty cycles", r + 16'h000a, c);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // =====================================================================
    // Main sequence
    // =====================================================================
    initial begin
        repeat (6) @(posedge sys_clk);
        sys_rst <= 1'b0;
        idle(1);
        rd16(frtc_pkg::count_high_addr, v0);
        chk("count after power-on", frtc_pkg::count_preset, v0);
        rdchk("unmapped read", 8'h30, 8'h00);
        $display("test reset done");
        idle(20);
        count_check(frtc_pkg::alt_count_high_addr, frtc_pkg::count_high_addr);
        count_check(frtc_pkg::count_high_addr, frtc_pkg::alt_count_high_addr);
        $display("test counting done");
        wr(frtc_pkg::timer_flags_addr, 8'h00);
        rdchk("flags after wrap", frtc_pkg::timer_flags_addr, 8'h20);
        rd(frtc_pkg::alt_count_low_addr, b);
        rdchk("flags after alt read", frtc_pkg::timer_flags_addr, 8'h20);
        wr(frtc_pkg::timer_control_addr, 8'h20);
        irq_check(1'b1);
        rd(frtc_pkg::count_low_addr, b);
        rdchk("flags after clear", frtc_pkg::timer_flags_addr, 8'h00);
        irq_check(1'b0);
        dev_reset();
        rd16(frtc_pkg::count_high_addr, v0);
        chk("count after device reset", frtc_pkg::count_preset, v0);
        idle(30);
        irq_check(1'b0);
        rd(frtc_pkg::count_low_addr, b);
        rdchk("flags without arming", frtc_pkg::timer_flags_addr, 8'h20);
        rd(frtc_pkg::count_low_addr, b);
        $display("test overflow done");
        // Prescaler phase leaves the offset at two or three counts
        for (int k = 0; k < 6; k++) begin
            wr(frtc_pkg::analog_control_addr, {3'h0, cases[k][3], 4'h0});
            wr(frtc_pkg::timer_control_addr, {6'h00, cases[k][4], 1'b0});
            rd16(frtc_pkg::alt_count_high_addr, v0);
            i_frtc_capture_src.drive(cases[k][2], cases[k][1], 0);
            idle(6);
            rdchk("capture flag", frtc_pkg::timer_flags_addr, cases[k][0] ? 8'h80 : 8'h00);
            rd16(frtc_pkg::capture_high_addr, cap);
            v1 = cap - v0;
            if (cases[k][0]) begin
                chk("capture offset", 16'h0001, {15'h0000, v1 >= 16'h0001 && v1 <= 16'h0003});
                last_cap = cap;
            end else begin
                chk("capture kept", last_cap, cap);
            end
        end
        // Blocked capture: flag sets, value stays, resets keep both
        i_frtc_capture_src.drive(1'b1, 1'b0, 3);
        idle(6);
        rd(frtc_pkg::capture_high_addr, b);
        i_frtc_capture_src.drive(1'b1, 1'b1, 3);
        idle(8);
        rdchk("flag while blocked", frtc_pkg::timer_flags_addr, 8'h80);
        dev_reset();
        rdchk("flag after reset", frtc_pkg::timer_flags_addr, 8'h80);
        rd16(frtc_pkg::capture_high_addr, cap);
        chk("capture while blocked", last_cap, cap);
        rdchk("control after reset", frtc_pkg::timer_control_addr, 8'h02);
        $display("test capture done");
        summarize();
    end
endmodule // tb_top
